// *** inc/adcck_consts.svh ***
// constants for the conversion clock and converter control block
//
// Behaviour
// - conversion clock divided by 1, 2, 4 or 8
// - division factor held in register 3
// - divider same for oscillator or external clock
// - oscillator off: clock pin is an input
// - pin or bit D4 reg 7 drives oscillator out
// - D5 and D3 set: oscillator clocks reference continuously
// - converter bias only during a conversion
// - register port independent of the conversion clock
// - three-bit gain field in register 4
// - four-bit channel field steers input switches
// - one channel bit swaps differential polarity
// - result bit 0 is OR of fault comparators
// - register 2 holds faults of last conversion
// - two's complement result, either bit order readable
// - differential codes span -8192 to 8191
// - single-ended codes span 0 to 8191
// - low result bit D1 always reads zero
// - approximation phase takes 14 divided clocks
// - four general pins individually input or output
// - dedicated pins: edge select, reset, oscillator enable
// - conversion 50 divided clocks, first 36 capture
// - rising edge on trigger pin starts conversion
// - busy high while a conversion runs
// - reset, start, oscillator: pin OR register bit
`ifndef ADCCK_CONSTS_SVH
`define ADCCK_CONSTS_SVH

// register indices, byte address is four times the index
`define ADCCK_IDX_RES_LO 3'h0
`define ADCCK_IDX_RES_HI 3'h1
`define ADCCK_IDX_FAULT 3'h2
`define ADCCK_IDX_CTRL 3'h3
`define ADCCK_IDX_GAINMUX 3'h4
`define ADCCK_IDX_GPIO_DATA 3'h5
`define ADCCK_IDX_GPIO_DIR 3'h6
`define ADCCK_IDX_OSCREF 3'h7

// field positions
`define ADCCK_CTRL_DF_LSB 0
`define ADCCK_CTRL_LSBF_BIT 5
`define ADCCK_GM_CNV_BIT 7
`define ADCCK_GM_GAIN_LSB 4
`define ADCCK_CH_SE_BIT 3
`define ADCCK_CH_SWAP_BIT 2
`define ADCCK_OR_SWRST_BIT 7
`define ADCCK_OR_REFERENCE_OSCILLATOR_BIT_BIT 5
`define ADCCK_OR_OSCILLATOR_ENABLE_BIT_BIT 4
`define ADCCK_OR_REFERENCE_ENABLE_BIT_BIT 3

// reset value of every register
`define ADCCK_REG_RESET 8'h00

// conversion sequence in divided clocks
`define ADCCK_CONV_CYCLES 6'h32
`define ADCCK_CAPTURE_CYCLES 6'h24
`define ADCCK_SAR_CYCLES 6'h0E

// timing
`define ADCCK_ACLK_FREQ_KHZ 10000
`define ADCCK_OSC_FREQ_KHZ 2500
`define ADCCK_OSC_HALF_CYCLES (`ADCCK_ACLK_FREQ_KHZ / (2 * `ADCCK_OSC_FREQ_KHZ))

`endif

// *** inc/adcck_pkg.sv ***
// types of the conversion clock and converter control block
package adcck_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_SAR = 3'b100
  } adcck_conv_state_t;
  typedef logic [1:0] adcck_resp_t;
endpackage

// *** hw/adcck_ctrl.sv ***
// conversion clock, sequencer, configuration registers and axi4-lite slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "adcck_consts.svh"
module adcck_ctrl #(
  parameter int FAULT_W = 4,
  parameter int OSC_HALF = `ADCCK_OSC_HALF_CYCLES
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output adcck_pkg::adcck_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output adcck_pkg::adcck_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  // dedicated pins
  input wire logic reset_pin,
  input wire logic edge_select_pin,
  input wire logic oscillator_enable_pin,
  input wire logic convert_pin,
  output logic busy,
  output logic sclk_rising_active,
  // conversion clock pin, two-way
  input wire logic conversion_clock_pin_in,
  output logic conversion_clock_pin_out,
  output logic conversion_clock_pin_oe,
  // general purpose pins, two-way
  input wire logic [3:0] general_purpose_pins_in,
  output logic [3:0] general_purpose_pins_out,
  output logic [3:0] general_purpose_pins_oe,
  // analog side
  input wire logic [13:0] sar_code,
  input wire logic [FAULT_W-1:0] fault_in,
  output logic divided_conversion_clock,
  output logic [2:0] gain_select_field,
  output logic [3:0] channel_select_field,
  output logic bias_en,
  output logic sar_phase,
  output logic osc_run,
  output logic ref_clk_en,
  output logic ref_en,
  output logic result_lsb_first
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic aw_got, w_got, next_aw_got, next_w_got;
  logic [2:0] widx, next_widx;
  logic [7:0] wbyte, next_wbyte;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [31:0] next_rdata;
  adcck_pkg::adcck_resp_t next_bresp, next_rresp;
  logic do_wr, wr_ok;
  logic [7:0] rd_val;
  logic [7:0] ctrl, gainmux, gpio_data, gpio_dir, oscref;
  logic [7:0] next_ctrl, next_gainmux, next_gpio_data, next_gpio_dir, next_oscref;
  logic soft_rst, next_soft_rst, mrst, cnv_wr;
  logic [7:0] osc_cnt, next_osc_cnt;
  logic osc_lvl, next_osc_lvl, next_osc_run, osc_on;
  logic conversion_clock_pin_d, conversion_clock_pin_rise, divided_conversion_clock_tick, next_divided_conversion_clock;
  logic [2:0] presc, next_presc, df_mask;
  adcck_pkg::adcck_conv_state_t state, next_state;
  logic [5:0] cnt, next_cnt;
  logic start_pend, next_start_pend, conv_d, trigger, next_busy;
  logic [1:0] df_act, next_df_act;
  logic se_act, next_se_act, swap_act, next_swap_act;
  logic [FAULT_W-1:0] fault_acc, next_fault_acc, fault_st, next_fault_st;
  logic [7:0] res_lo, res_hi, next_res_lo, next_res_hi;
  logic [13:0] code;
  logic [3:0] gp_read;

  // master reset from pin or register bit
  assign mrst = reset_pin | soft_rst;
  assign do_wr = aw_got & w_got & ~bvalid;
  assign wr_ok = do_wr & (bresp == 2'b00) & (widx >= `ADCCK_IDX_CTRL);
  assign cnv_wr = wr_ok & (widx == `ADCCK_IDX_GAINMUX) & wbyte[`ADCCK_GM_CNV_BIT];

  // ----------------------------------------------------------------
  // axi4-lite slave, clocked by aclk only
  // ----------------------------------------------------------------
  // per-bit pin read value
  generate
    for (genvar i = 0; i < 4; i++) begin : g_gp
      assign gp_read[i] = gpio_dir[i] ? gpio_data[i] : general_purpose_pins_in[i];
    end
  endgenerate

  // read mux, unmapped reads zero
  always_comb begin
    unique case (araddr[4:2])
      `ADCCK_IDX_RES_LO: rd_val = res_lo;
      `ADCCK_IDX_RES_HI: rd_val = res_hi;
      `ADCCK_IDX_FAULT: rd_val = 8'(fault_st);
      `ADCCK_IDX_CTRL: rd_val = ctrl;
      `ADCCK_IDX_GAINMUX: rd_val = gainmux;
      `ADCCK_IDX_GPIO_DATA: rd_val = {4'h0, gp_read};
      `ADCCK_IDX_GPIO_DIR: rd_val = gpio_dir;
      `ADCCK_IDX_OSCREF: rd_val = oscref;
    endcase
  end

  // address and data taken in either order, answered together
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_widx = widx;
    next_wbyte = wbyte;
    next_bvalid = bvalid & ~bready;
    next_bresp = bresp;
    if (awvalid & awready) begin
      next_aw_got = 1'b1;
      next_widx = awaddr[4:2];
      next_bresp = (awaddr[7:5] != 3'h0 || awaddr[1:0] != 2'h0) ? 2'b10 : 2'b00;
    end
    if (wvalid & wready) begin
      next_w_got = 1'b1;
      next_wbyte = wstrb[0] ? wdata[7:0] : 8'h00;
    end
    if (do_wr) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
    end
    next_awready = ~next_aw_got & ~next_bvalid;
    next_wready = ~next_w_got & ~next_bvalid;
    next_rvalid = rvalid & ~rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid & arready) begin
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, (araddr[7:5] == 3'h0 && araddr[1:0] == 2'h0) ? rd_val : 8'h00};
      next_rresp = (araddr[7:5] != 3'h0 || araddr[1:0] != 2'h0) ? 2'b10 : 2'b00;
    end
    next_arready = ~next_rvalid;
  end

  // bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      widx <= 3'h0;
      wbyte <= 8'h00;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'b00;
    end else if (ce) begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      widx <= next_widx;
      wbyte <= next_wbyte;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_gainmux = {1'b0, gainmux[6:0]};
    next_gpio_data = gpio_data;
    next_gpio_dir = gpio_dir;
    next_oscref = {1'b0, oscref[6:0]};
    next_soft_rst = 1'b0;
    if (wr_ok) begin
      unique case (widx)
        `ADCCK_IDX_CTRL: next_ctrl = wbyte;
        `ADCCK_IDX_GAINMUX: next_gainmux = {1'b0, wbyte[6:0]};
        `ADCCK_IDX_GPIO_DATA: next_gpio_data = {4'h0, wbyte[3:0]};
        `ADCCK_IDX_GPIO_DIR: next_gpio_dir = {4'h0, wbyte[3:0]};
        `ADCCK_IDX_OSCREF: begin
          next_oscref = {1'b0, wbyte[6:0]};
          next_soft_rst = wbyte[`ADCCK_OR_SWRST_BIT];
        end
        default: next_ctrl = ctrl;
      endcase
    end
    if (mrst) begin
      next_ctrl = `ADCCK_REG_RESET;
      next_gainmux = `ADCCK_REG_RESET;
      next_gpio_data = `ADCCK_REG_RESET;
      next_gpio_dir = `ADCCK_REG_RESET;
      next_oscref = `ADCCK_REG_RESET;
    end
  end

  // configuration flops and their pin copies
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `ADCCK_REG_RESET;
      gainmux <= `ADCCK_REG_RESET;
      gpio_data <= `ADCCK_REG_RESET;
      gpio_dir <= `ADCCK_REG_RESET;
      oscref <= `ADCCK_REG_RESET;
      soft_rst <= 1'b0;
      gain_select_field <= 3'h0;
      channel_select_field <= 4'h0;
      general_purpose_pins_out <= 4'h0;
      general_purpose_pins_oe <= 4'h0;
      result_lsb_first <= 1'b0;
      ref_en <= 1'b0;
      sclk_rising_active <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      gainmux <= next_gainmux;
      gpio_data <= next_gpio_data;
      gpio_dir <= next_gpio_dir;
      oscref <= next_oscref;
      soft_rst <= next_soft_rst;
      gain_select_field <= next_gainmux[6:4];
      channel_select_field <= next_gainmux[3:0];
      general_purpose_pins_out <= next_gpio_data[3:0];
      general_purpose_pins_oe <= next_gpio_dir[3:0];
      result_lsb_first <= next_ctrl[`ADCCK_CTRL_LSBF_BIT];
      ref_en <= next_oscref[`ADCCK_OR_REFERENCE_ENABLE_BIT_BIT];
      sclk_rising_active <= edge_select_pin;
    end
  end

  // ----------------------------------------------------------------
  // oscillator and prescaler
  // ----------------------------------------------------------------
  assign osc_on = oscillator_enable_pin | oscref[`ADCCK_OR_OSCILLATOR_ENABLE_BIT_BIT];
  // clock sensed at the pin whichever end drives it
  assign conversion_clock_pin_rise = conversion_clock_pin_in & ~conversion_clock_pin_d;
  assign df_mask = 3'((4'h1 << df_act) - 4'h1);
  assign divided_conversion_clock_tick = conversion_clock_pin_rise & (presc == df_mask);

  always_comb begin
    next_osc_run = osc_on | (oscref[`ADCCK_OR_REFERENCE_OSCILLATOR_BIT_BIT] & oscref[`ADCCK_OR_REFERENCE_ENABLE_BIT_BIT]);
    next_osc_cnt = osc_cnt;
    next_osc_lvl = osc_lvl;
    if (!next_osc_run) begin
      next_osc_cnt = 8'h00;
      next_osc_lvl = 1'b0;
    end else if (osc_cnt >= 8'(OSC_HALF - 1)) begin
      next_osc_cnt = 8'h00;
      next_osc_lvl = ~osc_lvl;
    end else begin
      next_osc_cnt = osc_cnt + 8'h01;
    end
    next_presc = presc;
    if (conversion_clock_pin_rise) begin
      next_presc = divided_conversion_clock_tick ? 3'h0 : presc + 3'h1;
    end
    next_divided_conversion_clock = (df_act == 2'h0) ? conversion_clock_pin_in : (next_presc <= (df_mask >> 1));
  end

  // oscillator, pin drive and divider flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt <= 8'h00;
      osc_lvl <= 1'b0;
      osc_run <= 1'b0;
      ref_clk_en <= 1'b0;
      conversion_clock_pin_d <= 1'b0;
      presc <= 3'h0;
      divided_conversion_clock <= 1'b0;
      conversion_clock_pin_out <= 1'b0;
      conversion_clock_pin_oe <= 1'b0;
    end else if (ce) begin
      osc_cnt <= next_osc_cnt;
      osc_lvl <= next_osc_lvl;
      osc_run <= next_osc_run;
      ref_clk_en <= oscref[`ADCCK_OR_REFERENCE_OSCILLATOR_BIT_BIT] & oscref[`ADCCK_OR_REFERENCE_ENABLE_BIT_BIT];
      conversion_clock_pin_d <= conversion_clock_pin_in;
      presc <= next_presc;
      divided_conversion_clock <= next_divided_conversion_clock;
      conversion_clock_pin_out <= next_osc_lvl;
      conversion_clock_pin_oe <= osc_on;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer and result
  // ----------------------------------------------------------------
  assign trigger = (convert_pin & ~conv_d) | cnv_wr;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_start_pend = start_pend | trigger;
    next_df_act = df_act;
    next_se_act = se_act;
    next_swap_act = swap_act;
    next_fault_acc = fault_acc;
    next_fault_st = fault_st;
    next_res_lo = res_lo;
    next_res_hi = res_hi;
    code = sar_code;
    if (swap_act && !se_act) begin
      code = (sar_code == 14'h2000) ? 14'h1FFF : 14'(~sar_code + 14'h0001);
    end
    if (se_act && code[13]) begin
      code = 14'h0000;
    end
    unique case (state)
      adcck_pkg::ST_IDLE: begin
        next_df_act = ctrl[`ADCCK_CTRL_DF_LSB +: 2];
        if (divided_conversion_clock_tick && start_pend) begin
          next_state = adcck_pkg::ST_CAPTURE;
          next_cnt = 6'h00;
          next_start_pend = trigger;
          next_se_act = gainmux[`ADCCK_CH_SE_BIT];
          next_swap_act = gainmux[`ADCCK_CH_SWAP_BIT];
          next_fault_acc = '0;
        end
      end
      adcck_pkg::ST_CAPTURE: begin
        next_fault_acc = fault_acc | fault_in;
        if (divided_conversion_clock_tick) begin
          next_cnt = cnt + 6'h01;
          if (cnt == `ADCCK_CAPTURE_CYCLES - 6'h01) begin
            next_state = adcck_pkg::ST_SAR;
          end
        end
      end
      adcck_pkg::ST_SAR: begin
        next_fault_acc = fault_acc | fault_in;
        if (divided_conversion_clock_tick) begin
          next_cnt = cnt + 6'h01;
          if (cnt == `ADCCK_CONV_CYCLES - 6'h01) begin
            next_state = adcck_pkg::ST_IDLE;
            next_fault_st = fault_acc | fault_in;
            next_res_hi = code[13:6];
            next_res_lo = {code[5:0], 1'b0, |(fault_acc | fault_in)};
          end
        end
      end
    endcase
    if (mrst) begin
      next_state = adcck_pkg::ST_IDLE;
      next_cnt = 6'h00;
      next_start_pend = 1'b0;
      next_fault_st = '0;
      next_res_lo = `ADCCK_REG_RESET;
      next_res_hi = `ADCCK_REG_RESET;
    end
    next_busy = next_state != adcck_pkg::ST_IDLE;
  end

  // sequencer flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= adcck_pkg::ST_IDLE;
      cnt <= 6'h00;
      start_pend <= 1'b0;
      conv_d <= 1'b0;
      df_act <= 2'h0;
      se_act <= 1'b0;
      swap_act <= 1'b0;
      fault_acc <= '0;
      fault_st <= '0;
      res_lo <= `ADCCK_REG_RESET;
      res_hi <= `ADCCK_REG_RESET;
      busy <= 1'b0;
      bias_en <= 1'b0;
      sar_phase <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      start_pend <= next_start_pend;
      conv_d <= convert_pin;
      df_act <= next_df_act;
      se_act <= next_se_act;
      swap_act <= next_swap_act;
      fault_acc <= next_fault_acc;
      fault_st <= next_fault_st;
      res_lo <= next_res_lo;
      res_hi <= next_res_hi;
      busy <= next_busy;
      bias_en <= next_busy;
      sar_phase <= next_state == adcck_pkg::ST_SAR;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce || mrst);

  property p_cap_len;
    state == adcck_pkg::ST_CAPTURE && divided_conversion_clock_tick && cnt == 6'h23 |=> state == adcck_pkg::ST_SAR;
  endproperty
  a_cap_len: assert property (p_cap_len) else $error("capture phase length wrong");

  property p_sar_span;
    state == adcck_pkg::ST_SAR |-> cnt >= 6'h24 && cnt <= 6'h31;
  endproperty
  a_sar_span: assert property (p_sar_span) else $error("sar phase outside 14 clocks");

  property p_busy;
    busy == (state != adcck_pkg::ST_IDLE) && bias_en == busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy or bias mismatches sequencer");

  property p_df_hold;
    state != adcck_pkg::ST_IDLE ##1 state != adcck_pkg::ST_IDLE |-> $stable(df_act);
  endproperty
  a_df_hold: assert property (p_df_hold) else $error("division changed mid conversion");

  property p_osc_out;
    osc_on |=> conversion_clock_pin_oe;
  endproperty
  a_osc_out: assert property (p_osc_out) else $error("oscillator not driving pin");

  property p_pin_in;
    !oscillator_enable_pin && !oscref[4] |=> !conversion_clock_pin_oe;
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("clock pin driven while input");

  property p_ovl;
    res_lo[0] == |fault_st && res_lo[1] == 1'b0;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload or zero bit wrong");

  property p_trigger;
    $rose(convert_pin) && state == adcck_pkg::ST_IDLE |=> start_pend || busy;
  endproperty
  a_trigger: assert property (p_trigger) else $error("convert edge lost");

  property p_tick;
    divided_conversion_clock_tick |-> conversion_clock_pin_rise && presc == df_mask;
  endproperty
  a_tick: assert property (p_tick) else $error("divided tick off prescale");

  property p_refclk;
    oscref[5] && oscref[3] |=> osc_run && ref_clk_en;
  endproperty
  a_refclk: assert property (p_refclk) else $error("reference clock not running");

  c_conv: cover property (state == adcck_pkg::ST_SAR && divided_conversion_clock_tick && cnt == 6'h31);
  c_queue: cover property (busy && trigger);
  c_df8: cover property (busy && df_act == 2'h3);
  c_wr_rd: cover property (bvalid ##[1:4] rvalid);
endmodule // adcck_ctrl

// *** bench/adcck_ext_clk.sv ***
// external conversion clock source seen at the two-way clock pin
`timescale 1ns/1ps
module adcck_ext_clk #(
  parameter int HALF_NS = 200
) (
  // pin control from the block
  input wire logic drive_oe,
  input wire logic osc_out,
  // level sensed at the pin
  output logic pin_level
);
  logic ext_clk;

  // free running source, 2.5 MHz, phase unrelated to aclk
  initial begin
    ext_clk = 1'b0;
    #37;
    forever #(HALF_NS) ext_clk = ~ext_clk;
  end

  // block drives the pin when enabled, otherwise the source does
  assign pin_level = drive_oe ? osc_out : ext_clk;
endmodule // adcck_ext_clk

// *** bench/adcck_ctrl_bench.sv ***
// self-checking bench for the conversion clock control block
`timescale 1ns/1ps
module adcck_ctrl_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic [1:0] r;} adcck_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rd;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic awready, wready, bvalid, arready, rvalid, busy, sclk_rising_active;
  adcck_pkg::adcck_resp_t bresp, rresp, resp;
  logic reset_pin = 1'b0, oscillator_enable_pin = 1'b0, convert_pin = 1'b0;
  logic ce = 1'b1, edge_select_pin = 1'b1;
  logic conversion_clock_pin_in, conversion_clock_pin_out, conversion_clock_pin_oe;
  logic divided_conversion_clock, bias_en, sar_phase, osc_run, ref_clk_en, ref_en;
  logic result_lsb_first;
  logic [3:0] general_purpose_pins_in = 4'h6, fault_in = 4'h0;
  logic [3:0] general_purpose_pins_out, general_purpose_pins_oe, channel_select_field;
  logic [2:0] gain_select_field;
  logic [13:0] sar_code = 14'h2ABD;
  logic [13:0] neg_code = 14'h0000 - 14'h2ABD;
  int fails = 0, samples_checked = 0, cycles = 0, busy_cnt = 0, sar_cnt = 0;
  adcck_row_t rows [9] = '{
    '{8'h0C, 8'h23, 8'h23, 2'h0}, '{8'h10, 8'h7F, 8'h7F, 2'h0}, '{8'h18, 8'h0F, 8'h0F, 2'h0},
    '{8'h14, 8'h0A, 8'h0A, 2'h0}, '{8'h1C, 8'h28, 8'h28, 2'h0}, '{8'h00, 8'h55, 8'h00, 2'h0},
    '{8'h08, 8'h33, 8'h00, 2'h0}, '{8'h20, 8'h11, 8'h00, 2'h2}, '{8'h0D, 8'h11, 8'h00, 2'h2}};

  adcck_ctrl #(.FAULT_W(4), .OSC_HALF(2)) adcck_ctrl_inst (
    .aclk, .aresetn, .ce, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .reset_pin, .edge_select_pin,
    .oscillator_enable_pin, .convert_pin, .busy, .sclk_rising_active, .conversion_clock_pin_in,
    .conversion_clock_pin_out, .conversion_clock_pin_oe, .general_purpose_pins_in,
    .general_purpose_pins_out, .general_purpose_pins_oe, .sar_code, .fault_in,
    .divided_conversion_clock, .gain_select_field, .channel_select_field, .bias_en, .sar_phase,
    .osc_run, .ref_clk_en, .ref_en, .result_lsb_first);

  adcck_ext_clk adcck_ext_clk_inst (.drive_oe(conversion_clock_pin_oe),
    .osc_out(conversion_clock_pin_out), .pin_level(conversion_clock_pin_in));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // write one register, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !dd) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // read one register into rd and resp
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
    chk("upper read bits", rdata[31:8], 32'h00000000);
  endtask

  // trigger a conversion by pin (trig zero) or by register write
  task automatic conv_start(input logic [7:0] trig);
    int n;
    busy_cnt = 0;
    sar_cnt = 0;
    if (trig == 8'h00) begin
      @(posedge aclk);
      convert_pin <= 1'b1;
      repeat (10) @(posedge aclk);
      convert_pin <= 1'b0;
    end else wr(8'h10, trig);
    n = 0;
    while (busy !== 1'b1 && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    chk("bias during conversion", bias_en, 1'b1);
  endtask

  // wait for the end and compare lengths in aclk cycles
  task automatic conv_end(input int exp_busy);
    while (busy === 1'b1) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk("busy length", busy_cnt, exp_busy);
    chk("sar length", sar_cnt, exp_busy * 14 / 50);
    chk("bias idle", bias_en, 1'b0);
  endtask

  // clock, cycle counts and hang limit
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (busy === 1'b1) busy_cnt++;
    if (sar_phase === 1'b1) sar_cnt++;
    if (cycles == 30000) begin
      fails++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      rdr(8'(i * 4));
      chk("reset value", rd, (i == 5) ? 8'h06 : 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("write resp", resp, rows[i].r);
      rdr(rows[i].a);
      chk("read data", rd, rows[i].q);
      chk("read resp", resp, rows[i].r);
    end
    chk("config outputs", {gain_select_field, channel_select_field, general_purpose_pins_oe,
      general_purpose_pins_out, result_lsb_first, ref_clk_en, ref_en, sclk_rising_active},
      {3'h7, 4'hF, 4'hF, 4'hA, 4'hF});
    // clock enable low freezes the pin copy, then it follows the edge select pin
    ce <= 1'b0;
    edge_select_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("ce freeze", sclk_rising_active, 1'b1);
    ce <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("edge select", sclk_rising_active, 1'b0);
    // general pins as inputs report the pin level
    wr(8'h18, 8'h00);
    rdr(8'h14);
    chk("gpio input", {general_purpose_pins_oe, rd}, {4'h0, 8'h06});
    // oscillator by register bit drives the clock pin
    wr(8'h1C, 8'h10);
    repeat (2) @(posedge aclk);
    chk("osc drive", {conversion_clock_pin_oe, osc_run}, 2'h3);
    // first conversion with faults present
    fault_in <= 4'h5;
    wr(8'h0C, 8'h00);
    conv_start(8'h80);
    repeat (8) @(posedge aclk);
    fault_in <= 4'h0;
    conv_end(200);
    rdr(8'h00);
    chk("result low", rd, {sar_code[5:0], 2'h1});
    rdr(8'h04);
    chk("result high", rd, sar_code[13:6]);
    rdr(8'h08);
    chk("fault status", rd, 8'h05);
    for (int df = 1; df < 4; df++) begin
      wr(8'h0C, 8'(df));
      conv_start(8'h80);
      conv_end(200 << df);
    end
    rdr(8'h08);
    chk("fault cleared", rd, 8'h00);
    // division change in mid conversion waits for the boundary
    wr(8'h0C, 8'h00);
    conv_start(8'h80);
    wr(8'h0C, 8'h03);
    conv_end(200);
    // external clock and pin trigger
    wr(8'h1C, 8'h00);
    wr(8'h0C, 8'h00);
    repeat (2) @(posedge aclk);
    chk("pin is input", conversion_clock_pin_oe, 1'b0);
    conv_start(8'h00);
    conv_end(200);
    // single ended clamps a negative code to zero
    conv_start(8'h88);
    conv_end(200);
    rdr(8'h00);
    chk("single low", rd, 8'h00);
    rdr(8'h04);
    chk("single high", rd, 8'h00);
    // polarity swap negates the code
    conv_start(8'h84);
    conv_end(200);
    rdr(8'h00);
    chk("swap low", rd, {neg_code[5:0], 2'h0});
    rdr(8'h04);
    chk("swap high", rd, neg_code[13:6]);
    // master reset pin clears the registers
    wr(8'h0C, 8'h21);
    @(posedge aclk);
    reset_pin <= 1'b1;
    @(posedge aclk);
    reset_pin <= 1'b0;
    repeat (2) @(posedge aclk);
    rdr(8'h0C);
    chk("reset pin ctrl", rd, 8'h00);
    rdr(8'h10);
    chk("reset pin gain", rd, 8'h00);
    // register reset bit clears the registers too
    wr(8'h0C, 8'h22);
    wr(8'h1C, 8'h80);
    rdr(8'h0C);
    chk("soft reset ctrl", rd, 8'h00);
    wrap_up();
  end
endmodule // adcck_ctrl_bench
